// ---- hw/dic_pkg.sv ----
package dic_pkg;

  localparam int NUM_INPUTS = 6;
  localparam int ASSIGN_W   = 3;
  localparam int SCHEME_W   = 2;
  localparam int FILTER_W   = 4;

  // Filter settle time and the cycle count derived from it at 25 MHz
  localparam int CLK_HZ       = 25_000_000;
  localparam int FILTER_NS    = 200;
  localparam int FILTER_COUNT = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    DIC_SCHEME_RESTART  = 2'b00,
    DIC_SCHEME_RUN_DIR  = 2'b01,
    DIC_SCHEME_PULSE    = 2'b10,
    DIC_SCHEME_FWD_REV  = 2'b11
  } dic_scheme_t;

  localparam logic [1:0] SCHEME_RST      = 2'h3;
  localparam logic [2:0] FWD_ASSIGN_RST  = 3'h1;
  localparam logic [2:0] REV_ASSIGN_RST  = 3'h2;
  localparam logic [2:0] FLIP_ASSIGN_RST = 3'h0;
  localparam logic [2:0] FAULT_ASSIGN_RST = 3'h0;
  localparam logic [2:0] SPEED1_ASSIGN   = 3'h3;
  localparam logic [2:0] SPEED2_ASSIGN   = 3'h4;
  localparam logic [2:0] ACK_ASSIGN      = 3'h5;
  localparam logic [2:0] REG_BLOCK_ASSIGN = 3'h6;

  // Fixed speed codes: 0 none, 1 = 10 Hz, 2 = 15 Hz, 3 = 20 Hz
  localparam logic [1:0] SPEED_NONE  = 2'h0;

endpackage

// ---- hw/dic_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module dic_decoder
  import dic_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_COUNT
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_IN,
  input  wire logic                   CE_IN,
  input  wire logic [NUM_INPUTS-1:0]  INPUTS_IN,
  input  wire logic [SCHEME_W-1:0]    START_STOP_SCHEME_IN,
  input  wire logic [ASSIGN_W-1:0]    FORWARD_START_ASSIGN_IN,
  input  wire logic [ASSIGN_W-1:0]    STOP_REVERSE_ASSIGN_IN,
  input  wire logic [ASSIGN_W-1:0]    DIRECTION_FLIP_ASSIGN_IN,
  input  wire logic [ASSIGN_W-1:0]    EXT_FAULT_NO_ASSIGN_IN,
  input  wire logic                   AUTO_RESTART_SETTING_IN,
  input  wire logic                   DRIVE_FAULT_IN,
  output logic                        RUN_OUT,
  output logic                        REVERSE_OUT,
  output logic                        FAULT_OUT,
  output logic [1:0]                  FIXED_SPEED_OUT,
  output logic                        REGULATOR_BLOCK_OUT
);

  logic [NUM_INPUTS-1:0] sync1;
  logic [NUM_INPUTS-1:0] sync2;
  logic [NUM_INPUTS-1:0] level;
  logic [NUM_INPUTS-1:0] level_d;
  logic [NUM_INPUTS-1:0] rise;
  logic                  pulse_run;
  logic                  run_allowed;
  logic                  fault;

  // Assignment decode: 0 disables, n picks input n
  // Code seven reads as off, never as an input
  function automatic logic pick(input logic [NUM_INPUTS-1:0] v, input logic [ASSIGN_W-1:0] a);
    logic r;
    r = 1'b0;
    if (a != 3'h0 && a <= 3'h6) begin
      r = v[a - 3'h1];
    end
    return r;
  endfunction

  // Two flops, since pins may move at any time
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (CE_IN) begin
      sync1 <= INPUTS_IN;
      sync2 <= sync1;
    end
  end

  // Filter each input; a bounce shorter than the window is ignored
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_filt
      logic [FILTER_W-1:0] cnt;
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          cnt        <= '0;
          level[gi]  <= 1'b0;
        end else if (CE_IN) begin
          if (sync2[gi] == level[gi]) begin
            cnt <= '0;
          end else if (cnt >= FILTER_W'(FILTER_CYCLES - 1)) begin
            cnt       <= '0;
            level[gi] <= sync2[gi];
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Delayed level for edge detection
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      level_d <= '0;
    end else if (CE_IN) begin
      level_d <= level;
    end
  end

  assign rise = level & ~level_d;

  // Function levels and edges after assignment decode
  logic fwd_lvl;
  logic rev_lvl;
  logic fwd_rise;
  logic rev_rise;
  logic flip_lvl;
  logic fault_rise;
  logic ack_rise;

  assign fwd_lvl    = pick(level, FORWARD_START_ASSIGN_IN);
  assign rev_lvl    = pick(level, STOP_REVERSE_ASSIGN_IN);
  assign fwd_rise   = pick(rise, FORWARD_START_ASSIGN_IN);
  assign rev_rise   = pick(rise, STOP_REVERSE_ASSIGN_IN);
  assign flip_lvl   = pick(level, DIRECTION_FLIP_ASSIGN_IN);
  assign fault_rise = pick(rise, EXT_FAULT_NO_ASSIGN_IN);
  assign ack_rise   = pick(rise, ACK_ASSIGN);

  // Pulse start/stop latch; stop wins when both arrive together
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pulse_run <= 1'b0;
    end else if (CE_IN) begin
      if (START_STOP_SCHEME_IN != DIC_SCHEME_PULSE || rev_rise) begin
        pulse_run <= 1'b0;
      end else if (fwd_rise) begin
        pulse_run <= 1'b1;
      end
    end
  end

  // Fault flag: a new fault wins over an acknowledge in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fault <= 1'b0;
    end else if (CE_IN) begin
      if (fault_rise || DRIVE_FAULT_IN) begin
        fault <= 1'b1;
      end else if (ack_rise) begin
        fault <= 1'b0;
      end else if (START_STOP_SCHEME_IN == DIC_SCHEME_RESTART && AUTO_RESTART_SETTING_IN) begin
        fault <= 1'b0;
      end
    end
  end

  // After a fault, schemes 1 to 3 need a fresh rising edge, or both direction inputs released, to run again
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      run_allowed <= 1'b0;
    end else if (CE_IN) begin
      if (fault) begin
        run_allowed <= 1'b0;
      end else if (START_STOP_SCHEME_IN == DIC_SCHEME_RESTART) begin
        run_allowed <= 1'b1;
      end else if (fwd_rise || rev_rise || !(fwd_lvl || rev_lvl)) begin
        run_allowed <= 1'b1;
      end
    end
  end

  // Run and direction ahead of the output flops
  logic       next_run;
  logic       next_rev;
  logic [1:0] next_speed;

  always_comb begin
    next_run = 1'b0;
    next_rev = 1'b0;
    case (START_STOP_SCHEME_IN)
      DIC_SCHEME_RESTART, DIC_SCHEME_FWD_REV: begin
        next_run = fwd_lvl ^ rev_lvl;
        next_rev = rev_lvl & ~fwd_lvl;
      end
      DIC_SCHEME_RUN_DIR: begin
        next_run = fwd_lvl;
        next_rev = rev_lvl;
      end
      default: begin
        next_run = pulse_run;
        next_rev = 1'b0;
      end
    endcase
    next_run   = next_run & run_allowed & ~fault;
    next_rev   = next_rev ^ flip_lvl;
    next_speed = {pick(level, SPEED2_ASSIGN), pick(level, SPEED1_ASSIGN)};
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RUN_OUT     <= 1'b0;
      REVERSE_OUT <= 1'b0;
    end else if (CE_IN) begin
      RUN_OUT     <= next_run;
      REVERSE_OUT <= next_rev;
    end
  end

  // Fault shown a cycle after the flag, so it never leads the run drop
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FAULT_OUT <= 1'b0;
    end else if (CE_IN) begin
      FAULT_OUT <= fault;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FIXED_SPEED_OUT     <= SPEED_NONE;
      REGULATOR_BLOCK_OUT <= 1'b0;
    end else if (CE_IN) begin
      FIXED_SPEED_OUT     <= next_speed;
      REGULATOR_BLOCK_OUT <= pick(level, REG_BLOCK_ASSIGN);
    end
  end

endmodule
`default_nettype wire

// ---- test/dic_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dic_switch_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] want_in,
  output logic      [5:0] pins_out
);
  initial pins_out = 6'h00;
  // Contacts move off the sampling edge
  always @(negedge clk_in) pins_out <= want_in;
endmodule
`default_nettype wire

// ---- test/dic_decoder_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dic_decoder_monitor
  import dic_pkg::*;
(
  input wire logic CLK_IN, RST_IN, CE_IN, AUTO_RESTART_SETTING_IN, DRIVE_FAULT_IN,
  input wire logic [NUM_INPUTS-1:0] INPUTS_IN,
  input wire logic [SCHEME_W-1:0] START_STOP_SCHEME_IN,
  input wire logic [ASSIGN_W-1:0] FORWARD_START_ASSIGN_IN, STOP_REVERSE_ASSIGN_IN,
  input wire logic [ASSIGN_W-1:0] DIRECTION_FLIP_ASSIGN_IN, EXT_FAULT_NO_ASSIGN_IN,
  input wire logic RUN_OUT, REVERSE_OUT, FAULT_OUT, REGULATOR_BLOCK_OUT,
  input wire logic [1:0] FIXED_SPEED_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wire dflt = FORWARD_START_ASSIGN_IN == 3'h1 && STOP_REVERSE_ASSIGN_IN == 3'h2 && DIRECTION_FLIP_ASSIGN_IN == 3'h0;
  wire sc3 = START_STOP_SCHEME_IN == 2'h3 && dflt;
  // Eight cycles outlasts sync plus filter at the bench setting
  sequence s_hold(b); b [*8]; endsequence
  property p_glitch; $changed(REGULATOR_BLOCK_OUT) |-> REGULATOR_BLOCK_OUT == $past(INPUTS_IN[5], 5); endproperty
  a_glitch: assert property (p_glitch) else $error("regulator block moved without held input");
  property p_speed; $changed(FIXED_SPEED_OUT) |-> FIXED_SPEED_OUT == $past(INPUTS_IN[3:2], 5); endproperty
  a_speed: assert property (p_speed) else $error("fixed speed code wrong");
  property p_lock; s_hold(sc3 && INPUTS_IN[1:0] == 2'h3) |-> !RUN_OUT; endproperty
  a_lock: assert property (p_lock) else $error("run with both directions held");
  property p_fwd; s_hold(sc3 && INPUTS_IN[1:0] == 2'h1) ##0 RUN_OUT |-> !REVERSE_OUT; endproperty
  a_fwd: assert property (p_fwd) else $error("forward run shows reverse");
  property p_sel; s_hold(START_STOP_SCHEME_IN == 2'h1 && dflt && INPUTS_IN[1:0] == 2'h3) ##0 RUN_OUT |-> REVERSE_OUT;
  endproperty
  a_sel: assert property (p_sel) else $error("reverse selector ignored");
  property p_ext; s_hold(EXT_FAULT_NO_ASSIGN_IN == 3'h4 && INPUTS_IN[3]) |-> FAULT_OUT; endproperty
  a_ext: assert property (p_ext) else $error("external fault not raised");
  property p_clr;
    $fell(FAULT_OUT) |-> START_STOP_SCHEME_IN == 2'h0 && AUTO_RESTART_SETTING_IN || $past(INPUTS_IN[4], 5);
  endproperty
  a_clr: assert property (p_clr) else $error("fault cleared without cause");
  property p_rst;
    s_hold(START_STOP_SCHEME_IN == 2'h0 && dflt && INPUTS_IN[1:0] == 2'h1 && !FAULT_OUT && !DRIVE_FAULT_IN) |-> RUN_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("held run not honoured");
endmodule
bind dic_decoder dic_decoder_monitor mon (.*);
`default_nettype wire

// ---- test/test_dic_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_dic_decoder;
  import dic_pkg::*;
  logic clk = 0, rst = 1, ce = 1, dflt = 0, ar = 0, run, reverse_run, flt, reg_b;
  logic [1:0] sc = 2'h3, spd;
  logic [2:0] fa = 3'h1, ra = 3'h2, da = 3'h0, ea = 3'h0;
  logic [5:0] want = 6'h00, pins, q[$];
  int failures = 0, checks = 0, cyc = 0, seed = 32'h055c, r;
  event smp;
  initial forever #20 clk = ~clk;
  dic_switch_model sw (.clk_in(clk), .want_in(want), .pins_out(pins));
  dic_decoder #(.FILTER_CYCLES(3)) uut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .INPUTS_IN(pins),
    .START_STOP_SCHEME_IN(sc), .FORWARD_START_ASSIGN_IN(fa), .STOP_REVERSE_ASSIGN_IN(ra),
    .DIRECTION_FLIP_ASSIGN_IN(da), .EXT_FAULT_NO_ASSIGN_IN(ea), .AUTO_RESTART_SETTING_IN(ar),
    .DRIVE_FAULT_IN(dflt), .RUN_OUT(run), .REVERSE_OUT(reverse_run), .FAULT_OUT(flt), .FIXED_SPEED_OUT(spd),
    .REGULATOR_BLOCK_OUT(reg_b));
  task chk(input logic [5:0] seen, input logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hold well past sync plus filter, then note {run,rev,fault,speed,block}
  task st(input logic [5:0] in, input logic [5:0] e);
    want = in;
    repeat (12) @(negedge clk);
    q.push_back(e);
    ->smp;
  endtask
  task pl(input logic [5:0] in, input int n);
    want = in;
    repeat (n) @(negedge clk);
  endtask
  always @(smp) chk({run, reverse_run, flt, spd, reg_b}, q.pop_front());
  always @(posedge clk) if (++cyc == 3000) begin
    failures++;
    test_done;
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    st(6'h01, 6'h20);
    st(6'h03, 6'h00);
    st(6'h00, 6'h00);
    st(6'h02, 6'h30);
    st(6'h04, 6'h02);
    st(6'h08, 6'h04);
    st(6'h0c, 6'h06);
    st(6'h20, 6'h01);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      st({r[5:2], 2'h0}, {3'h0, r[3:2], r[5]});
    end
    st(6'h00, 6'h00);
    pl(6'h20, 1);
    st(6'h00, 6'h00);
    sc = 2'h1;
    st(6'h01, 6'h20);
    st(6'h03, 6'h30);
    st(6'h00, 6'h00);
    sc = 2'h2;
    pl(6'h01, 5);
    st(6'h00, 6'h20);
    pl(6'h02, 5);
    st(6'h00, 6'h00);
    sc = 2'h3;
    da = 3'h3;
    st(6'h05, 6'h32);
    da = 3'h0;
    fa = 3'h6;
    st(6'h20, 6'h21);
    fa = 3'h0;
    st(6'h01, 6'h00);
    fa = 3'h1;
    ea = 3'h4;
    st(6'h08, 6'h0c);
    st(6'h00, 6'h08);
    st(6'h10, 6'h00);
    ea = 3'h0;
    sc = 2'h0;
    ar = 1;
    dflt = 1;
    st(6'h01, 6'h08);
    dflt = 0;
    st(6'h01, 6'h20);
    ar = 0;
    dflt = 1;
    pl(6'h01, 4);
    dflt = 0;
    st(6'h01, 6'h08);
    st(6'h11, 6'h20);
    // Enable low freezes every flop, outputs included
    ce = 0;
    st(6'h00, 6'h20);
    ce = 1;
    st(6'h00, 6'h00);
    st(6'h01, 6'h20);
    // Mid-run reset clears outputs, held level runs again after it
    rst = 1;
    @(negedge clk);
    q.push_back(6'h00);
    ->smp;
    @(negedge clk);
    rst = 0;
    st(6'h01, 6'h20);
    test_done;
  end
endmodule
`default_nettype wire
